// ---- design/scf_sync_char_framer.sv ----
// receive-side character framer for a synchronous serial line
//
// Behaviour
// - restart or resync request forces sync search
// - shift bits in, compare with sync register
// - mismatch: slide one bit, compare again
// - after match, flag every eighth bit
// - optional double sync before framing
`timescale 1ns/10ps
module scf_sync_char_framer (
   // system clock and reset
   input  wire logic                            i_clk,
   input  wire logic                            i_sys_rst,
   // configuration, system domain
   input  wire logic [scf_pkg::SCF_CHAR_W-1:0]  i_sync_char,
   input  wire logic                            i_double_sync,
   input  wire logic                            i_resync,
   // line side
   input  wire logic                            i_rx_clk,
   input  wire logic                            i_rx_data,
   // character output, system domain
   output logic [scf_pkg::SCF_CHAR_W-1:0]       o_char,
   output logic                                 o_char_valid,
   input  wire logic                            i_char_ready,
   output logic                                 o_in_sync
);
   import scf_pkg::*;

   // bit counter step; wraps after the eighth bit of a character
   function automatic logic [2:0] scf_next_cnt(input logic [2:0] cnt);
      scf_next_cnt = cnt + SCF_CNT_ONE;
   endfunction

   // buffer holds at least one word
   function automatic logic scf_not_empty(input logic [1:0] fill);
      scf_not_empty = (fill != SCF_PTR_ZERO);
   endfunction

   // ---------------- reset and resync into the link domain ----------------
   // reset and resync reach the link domain as a level through two flops
   logic rst_meta_reg, rst_meta_next, rst_link_reg, rst_link_next;
   logic rsy_req_reg, rsy_req_next;
   always_comb begin
      rsy_req_next = i_sys_rst | i_resync;
   end
   always_ff @(posedge i_clk) begin
      rsy_req_reg <= rsy_req_next;
   end
   always_comb begin
      rst_meta_next = rsy_req_reg;
      rst_link_next = rst_meta_reg;
   end
   always_ff @(posedge i_rx_clk) begin
      rst_meta_reg <= rst_meta_next;
      rst_link_reg <= rst_link_next;
   end

   // ---------------- sync config into the link domain ----------------
   // sync character is static while searching; two flops guard metastability
   logic [SCF_CHAR_W-1:0] sc_meta_reg, sc_link_reg, sc_meta_next, sc_link_next;
   logic                  ds_meta_reg, ds_link_reg, ds_meta_next, ds_link_next;
   always_comb begin
      sc_meta_next = i_sync_char;
      sc_link_next = sc_meta_reg;
      ds_meta_next = i_double_sync;
      ds_link_next = ds_meta_reg;
   end
   always_ff @(posedge i_rx_clk) begin
      sc_meta_reg <= sc_meta_next;
      sc_link_reg <= sc_link_next;
      ds_meta_reg <= ds_meta_next;
      ds_link_reg <= ds_link_next;
   end

   // ---------------- link-domain framer ----------------
   scf_state_t            state_reg, state_next;
   logic [SCF_CHAR_W-1:0] sr_reg, sr_next;
   logic [2:0]            cnt_reg, cnt_next;
   logic [SCF_CHAR_W-1:0] hold_reg, hold_next;
   logic                  tgl_reg, tgl_next;
   logic [SCF_CHAR_W-1:0] shifted;
   logic                  match;

   always_comb begin
      shifted    = {sr_reg[SCF_CHAR_W-2:0], i_rx_data};
      match      = (shifted == sc_link_reg);
      state_next = state_reg;
      sr_next    = shifted;
      cnt_next   = cnt_reg;
      hold_next  = hold_reg;
      tgl_next   = tgl_reg;
      if (rst_link_reg) begin
         state_next = SCF_ST_SEARCH;
         sr_next    = SCF_SR_RESET;
         cnt_next   = SCF_CNT_ZERO;
         hold_next  = SCF_SR_RESET;
         tgl_next   = 1'b0;
      end else begin
         case (state_reg)
            SCF_ST_SEARCH: begin
               cnt_next = SCF_CNT_ZERO;
               if (match) begin
                  state_next = ds_link_reg ? SCF_ST_SECOND : SCF_ST_FRAMED;
               end
            end
            SCF_ST_SECOND: begin
               // next eight bits must be sync again
               cnt_next = scf_next_cnt(cnt_reg);
               if (cnt_reg == SCF_CNT_LAST) begin
                  state_next = match ? SCF_ST_FRAMED : SCF_ST_SEARCH;
                  cnt_next   = SCF_CNT_ZERO;
               end
            end
            SCF_ST_FRAMED: begin
               cnt_next = scf_next_cnt(cnt_reg);
               if (cnt_reg == SCF_CNT_LAST) begin
                  hold_next = shifted;
                  tgl_next  = ~tgl_reg;
               end
            end
            default: state_next = SCF_ST_SEARCH;
         endcase
      end
   end
   // toggle clears inside the link reset; any edge it makes then lands while the
   // system side is still flushing, so reset must span four line clocks
   always_ff @(posedge i_rx_clk) begin
      state_reg <= state_next;
      sr_reg    <= sr_next;
      cnt_reg   <= cnt_next;
      hold_reg  <= hold_next;
      tgl_reg   <= tgl_next;
   end

   // framed flag from a flop, so the crossing never sees a state-decode glitch
   logic framed_reg, framed_next;
   always_comb begin
      framed_next = (state_next == SCF_ST_FRAMED);
   end
   always_ff @(posedge i_rx_clk) begin
      framed_reg <= framed_next;
   end

   // ---------------- crossing back to the system clock ----------------
   // toggle handshake; hold word is stable for eight line bits after a toggle,
   // far longer than the three system cycles the capture needs
   logic tg_meta_reg, tg_sync_reg, tg_seen_reg;
   logic tg_meta_next, tg_sync_next, tg_seen_next;
   logic is_meta_reg, is_sync_reg, is_meta_next, is_sync_next;
   logic char_evt;
   always_comb begin
      tg_meta_next = tgl_reg;
      tg_sync_next = tg_meta_reg;
      tg_seen_next = tg_sync_reg;
      is_meta_next = framed_reg;
      is_sync_next = is_meta_reg;
      char_evt     = (tg_sync_reg != tg_seen_reg);
   end
   always_ff @(posedge i_clk) begin
      tg_meta_reg <= tg_meta_next;
      tg_sync_reg <= tg_sync_next;
      tg_seen_reg <= tg_seen_next;
      is_meta_reg <= is_meta_next;
      is_sync_reg <= is_sync_next;
   end

   // ---------------- two-entry output buffer ----------------
   logic [SCF_CHAR_W-1:0] buf_reg [0:1];
   logic [SCF_CHAR_W-1:0] buf_next [0:1];
   logic [1:0]            fill_reg, fill_next;
   logic                  rd_reg, rd_next, wr_reg, wr_next;
   logic                  push, pop;
   logic                  insync_reg, insync_next;

   always_comb begin
      // a word arriving with both entries full is dropped; at one word per
      // eight line bits the reader must keep up on average
      push        = char_evt && (fill_reg != SCF_FILL_FULL);
      pop         = scf_not_empty(fill_reg) && i_char_ready;
      buf_next[0] = buf_reg[0];
      buf_next[1] = buf_reg[1];
      wr_next     = wr_reg;
      rd_next     = rd_reg;
      fill_next   = fill_reg;
      insync_next = is_sync_reg;
      if (push) begin
         buf_next[wr_reg] = hold_reg;
         wr_next          = ~wr_reg;
      end
      if (pop) begin
         rd_next = ~rd_reg;
      end
      if (push && !pop) begin
         fill_next = fill_reg + SCF_PTR_ONE;
      end else if (pop && !push) begin
         fill_next = fill_reg - SCF_PTR_ONE;
      end
      if (i_sys_rst || i_resync) begin
         fill_next   = SCF_PTR_ZERO;
         wr_next     = 1'b0;
         rd_next     = 1'b0;
         insync_next = 1'b0;
      end
   end
   always_ff @(posedge i_clk) begin
      buf_reg[0] <= buf_next[0];
      buf_reg[1] <= buf_next[1];
      fill_reg   <= fill_next;
      wr_reg     <= wr_next;
      rd_reg     <= rd_next;
      insync_reg <= insync_next;
   end

   always_comb begin
      o_char       = buf_reg[rd_reg];
      o_char_valid = scf_not_empty(fill_reg);
      o_in_sync    = insync_reg;
   end
endmodule

// ---- inc/scf_pkg.sv ----
// shared constants and types for the sync character framer
package scf_pkg;
   localparam int         SCF_CHAR_W    = 8;
   localparam logic [2:0] SCF_CNT_LAST  = 3'h7;
   localparam logic [2:0] SCF_CNT_ZERO  = 3'h0;
   localparam logic [2:0] SCF_CNT_ONE   = 3'h1;
   localparam logic [7:0] SCF_SR_RESET  = 8'h00;
   localparam logic [1:0] SCF_PTR_ZERO  = 2'h0;
   localparam logic [1:0] SCF_PTR_ONE   = 2'h1;
   localparam logic [1:0] SCF_FILL_FULL = 2'h2;

   typedef enum logic [1:0] {
      SCF_ST_SEARCH = 2'b00,
      SCF_ST_SECOND = 2'b01,
      SCF_ST_FRAMED = 2'b10
   } scf_state_t;
endpackage

// ---- verification/scf_line_model.sv ----
// line partner: receive clock and serial data
`timescale 1ns/10ps
module scf_line_model (
   // line leads
   output logic o_rx_clk,
   output logic o_rx_data
);
   logic q[$];
   initial begin
      o_rx_clk = 1'b0;
      o_rx_data = 1'b0;
   end
   always #80 o_rx_clk = ~o_rx_clk;
   // idle toggles so stale bits never pass for data
   always @(negedge o_rx_clk) o_rx_data <= q.size() ? q.pop_front() : ~o_rx_data;
   task automatic send(input logic [7:0] c);
      for (int i = 7; i >= 0; i--) q.push_back(c[i]);
   endtask
endmodule

// ---- verification/scf_sync_char_framer_asserts.sv ----
// port assertions for the framer
`timescale 1ns/10ps
module scf_sync_char_framer_asserts (
   // system side
   input wire logic       i_clk,
   input wire logic       i_sys_rst,
   input wire logic [7:0] i_sync_char,
   input wire logic       i_double_sync,
   input wire logic       i_resync,
   // line side
   input wire logic       i_rx_clk,
   input wire logic       i_rx_data,
   // output side
   input wire logic [7:0] o_char,
   input wire logic       o_char_valid,
   input wire logic       i_char_ready,
   input wire logic       o_in_sync
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   sequence resync_hit;
      $rose(i_resync) ##1 i_resync[*3];
   endsequence
   reset_clear_a: assert property ($fell(i_sys_rst) |-> !o_char_valid && !o_in_sync)
      else $error("outputs set after reset");
   resync_search_a: assert property (resync_hit |-> ##[0:40] !o_in_sync && !o_char_valid)
      else $error("resync ignored");
   no_early_char_a: assert property (o_char_valid && !i_resync |-> o_in_sync)
      else $error("char before sync");
   char_hold_a: assert property (o_char_valid && !i_char_ready && !i_resync |=>
      o_char_valid && $stable(o_char))
      else $error("char lost while stalled");
   framing_kept_a: assert property (o_in_sync && !i_resync |=> o_in_sync)
      else $error("framing dropped");
   sync_not_out_a: assert property ($rose(o_in_sync) |-> !o_char_valid)
      else $error("sync delivered as data");
endmodule
bind scf_sync_char_framer scf_sync_char_framer_asserts scf_sync_char_framer_asserts_inst (.*);

// ---- verification/tb_top.sv ----
// self-checking bench for the framer
`timescale 1ns/10ps
module tb_top;
   import scf_pkg::*;
   logic       i_clk = 1'b0, i_sys_rst = 1'b1, i_double_sync = 1'b0, i_resync = 1'b0;
   logic       i_char_ready = 1'b0, o_char_valid, o_in_sync, rx_clk, rx_data;
   logic [7:0] i_sync_char = 8'h16, o_char, sr = 8'h00;
   int         error_cnt = 0, checks = 0, st = 0, cnt = 0, cyc = 0, nch = 0;
   int         exp_q[$];
   always #12.5 i_clk = ~i_clk;
   scf_line_model scf_line_model_inst (.o_rx_clk(rx_clk), .o_rx_data(rx_data));
   scf_sync_char_framer scf_sync_char_framer_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .i_sync_char(i_sync_char), .i_double_sync(i_double_sync), .i_resync(i_resync),
      .i_rx_clk(rx_clk), .i_rx_data(rx_data), .o_char(o_char), .o_char_valid(o_char_valid),
      .i_char_ready(i_char_ready), .o_in_sync(o_in_sync));
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("error_cnt %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic clk(input int n);
      repeat (n) @(negedge i_clk);
   endtask
   always @(posedge rx_clk) begin
      sr = {sr[6:0], rx_data};
      cnt = (cnt + 1) % 8;
      if (i_sys_rst || i_resync) begin
         st = 0;
         exp_q.delete();
      end else if (st == 0 && sr == i_sync_char) begin
         st = i_double_sync ? 1 : 2;
         cnt = 0;
      end else if (st != 0 && cnt == 0) begin
         if (st == 2 && exp_q.size() < 2)
            exp_q.push_back(sr);
         nch++;
         st = (st == 1 && sr != i_sync_char) ? 0 : 2;
      end
   end
   // look between edges: the pop decision stands from falling edge to rising edge
   always @(negedge i_clk) begin
      #2;
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         stop_test();
      end
      if (o_char_valid === 1'b1 && i_char_ready === 1'b1)
         chk({1'b0, o_char}, exp_q.size() ? 9'(exp_q.pop_front()) : 9'h1FF);
   end
   initial begin
      void'($urandom(34108));
      clk(20);
      i_sys_rst = 1'b0;
      chk({7'h00, o_char_valid, o_in_sync}, 9'h000);
      for (int d = 0; d < 2; d++) begin
         i_double_sync = d[0];
         clk(30);
         scf_line_model_inst.send(8'h16);
         if (d == 1) begin
            scf_line_model_inst.send(8'h3C);
            clk(130);
            chk({8'h00, o_in_sync}, 9'h000);
            scf_line_model_inst.send(8'h16);
            scf_line_model_inst.send(8'h16);
         end
         repeat (6) scf_line_model_inst.send(8'($urandom));
         repeat (500) begin
            i_char_ready = 1'($urandom);
            clk(1);
         end
         chk({8'h00, o_in_sync}, 9'h001);
         i_char_ready = 1'b0;
         clk(300);
         @(nch);
         clk(10);
         i_char_ready = 1'b1;
         clk(30);
         i_resync = 1'b1;
         clk(60);
         chk({7'h00, o_char_valid, o_in_sync}, 9'h000);
         i_resync = 1'b0;
      end
      stop_test();
   end
endmodule
